//--- include/dasc_defines.svh
`ifndef DASC_DEFINES_SVH
`define DASC_DEFINES_SVH
// register byte offsets on the wishbone slave
`define DASC_OFF_WREG0    16'h0000
`define DASC_OFF_WREG1    16'h0002
`define DASC_OFF_WREG2    16'h0004
`define DASC_OFF_WREG3    16'h0006
`define DASC_OFF_WREG4    16'h0008
`define DASC_OFF_WREG5    16'h000a
`define DASC_OFF_WREG6    16'h000c
`define DASC_OFF_WREG7    16'h000e
`define DASC_OFF_SP       16'h001e
`define DASC_OFF_STACK_LIMIT_REG    16'h0020
`define DASC_OFF_SECCFG   16'h0040
`define DASC_OFF_STATUS   16'h0044
// reset values
`define DASC_RST_DEFAULT_WORK_REG     16'h0000
`define DASC_RST_SP       16'h0800
`define DASC_RST_SECCFG   16'h0000
// address limits
`define DASC_NEAR_MAX     16'h1fff
`define DASC_SFR_END      16'h0800
// security config field positions
`define DASC_SEC_BS_EN    0
`define DASC_SEC_SS_EN    1
`endif

//--- include/dasc_pkg.sv
package dasc_pkg;
    // one data access request from the execution core
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        isByte;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dasc_acc_s;
    // access kinds that touch the stack pointer
    typedef enum logic [4:0] {
        DASC_OP_NONE  = 5'b00001,
        DASC_OP_PUSH  = 5'b00010,
        DASC_OP_POP   = 5'b00100,
        DASC_OP_CALL  = 5'b01000,
        DASC_OP_EXCP  = 5'b10000
    } dasc_op_e;
    // single-register operations on working registers
    typedef enum logic [3:0] {
        DASC_X_NONE = 4'b0001,
        DASC_X_SEXT = 4'b0010,
        DASC_X_ZEXT = 4'b0100,
        DASC_X_BLD  = 4'b1000
    } dasc_xop_e;
    typedef logic [15:0] dasc_word_t;
endpackage : dasc_pkg

//--- rtl/data_access_stack_check.sv
// What this block does
// - word access at odd byte address raises an address error trap
// - misaligned read lets the instruction complete, then traps
// - misaligned write is suppressed at memory, then traps
// - byte load writes low byte of working register, upper byte kept
// - sign-extend turns low signed byte into signed 16-bit word
// - zero-extend clears upper byte of working register
// - word-only instructions never issue byte-size accesses
// - memory-direct address is 13 bits, range 0x0000 to 0x1fff
// - move memory-direct address is 16 bits over whole X space
// - stack pointer holds first free word; stack grows upward
// - pop pre-decrements the pointer, push post-increments it
// - call push stores the counter with upper byte cleared
// - exception push puts status low byte in counter upper byte
// - stack limit not reset; its bit zero always reads zero
// - every push effective address is compared with the limit; pops are not
// - push at pointer equal to limit is allowed; next push traps
// - stack access effective address below 0x0800 raises a stack error trap
// - boot secure ram reachable only from boot flash code when enabled
// - secure segment ram reachable only from secure flash code when enabled
// - byte read selects byte by address bit 0; byte write one half
// - unimplemented address reads zero and raises an address error trap
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/100ps
`include "dasc_defines.svh"
module dasc_data_access_stack_check #(
    parameter logic [15:0] IMPL_TOP    = 16'h27ff,
    parameter logic [15:0] BOOT_SECURE_RAM_BASE  = 16'h0800,
    parameter logic [15:0] BOOT_SECURE_RAM_TOP   = 16'h08ff,
    parameter logic [15:0] SECURE_SEGMENT_RAM_BASE  = 16'h0900,
    parameter logic [15:0] SECURE_SEGMENT_RAM_TOP   = 16'h09ff
) (
    input  wire logic                clk,
    input  wire logic                nrst,
    // wishbone classic slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [15:0]         wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic [31:0]              wb_dat_o,
    output logic                     wb_ack_o,
    // data access from the core address generators
    input  wire dasc_pkg::dasc_acc_s acc,
    input  wire logic                accDirect,
    input  wire logic                accMove,
    input  wire logic [15:0]         accDirAddr,
    input  wire logic                accWordOnly,
    input  wire logic                fromBootFlash,
    input  wire logic                fromSecFlash,
    // stack operations
    input  wire dasc_pkg::dasc_op_e  stackOp,
    input  wire logic [15:0]         pcValue,
    input  wire logic [7:0]          statusLowByte,
    // working register operations
    input  wire dasc_pkg::dasc_xop_e xop,
    input  wire logic [2:0]          xopReg,
    // data memory side
    output dasc_pkg::dasc_acc_s      memReq,
    input  wire logic [15:0]         memRdata,
    output logic [15:0]              readData,
    // exception side
    output logic                     addrErrTrap,
    output logic                     stackErrTrap,
    output logic                     accessDenied
);
    import dasc_pkg::*;

    // register state
    dasc_word_t  workReg_q [8];
    dasc_word_t  stackPointer_q;
    dasc_word_t  stackLimit_q;
    logic [1:0]  secCfg_q;
    logic [2:0]  sticky_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    dasc_word_t  readData_q;
    dasc_acc_s   memReq_q;
    logic        addrErr_q;
    logic        stackErr_q;
    logic        denied_q;

    // effective address selection for direct modes
    wire [15:0] nearAddr  = {3'b000, accDirAddr[12:0]};
    wire [15:0] moveAddr  = accDirAddr;
    wire [15:0] dataEa    = accDirect ? (accMove ? moveAddr : nearAddr) : acc.addr;

    // stack effective address: pop pre-decrements, push uses current pointer
    wire isPush   = (stackOp == DASC_OP_PUSH) || (stackOp == DASC_OP_CALL)
                  || (stackOp == DASC_OP_EXCP);
    wire isPop    = (stackOp == DASC_OP_POP);
    wire [15:0] popEa    = stackPointer_q - 16'h0002;
    wire [15:0] stackEa  = isPop ? popEa : stackPointer_q;
    wire        stackAcc = isPush || isPop;

    // pushed word for call and exception entry
    wire [15:0] callWord = {8'h00, pcValue[7:0]};
    wire [15:0] excpWord = {statusLowByte, pcValue[7:0]};
    wire [15:0] pushWord = (stackOp == DASC_OP_CALL) ? callWord
                         : (stackOp == DASC_OP_EXCP) ? excpWord : acc.wdata;

    // final access as seen by the checks
    wire [15:0] ea       = stackAcc ? stackEa : dataEa;
    wire        doAcc    = stackAcc || acc.valid;
    wire        doWrite  = stackAcc ? isPush : acc.write;
    wire        byteSize = stackAcc ? 1'b0 : (acc.isByte & ~accWordOnly);

    // alignment and implemented range
    wire misalign = doAcc && !byteSize && ea[0];
    wire unimpl   = doAcc && (ea > IMPL_TOP);

    // stack limit and underflow, same comparators for every push kind
    wire overLimit  = stackAcc && isPush && (stackEa > stackLimit_q);
    wire underflow  = stackAcc && (stackEa < `DASC_SFR_END);

    // secure ram windows
    wire inBs   = (ea >= BOOT_SECURE_RAM_BASE) && (ea <= BOOT_SECURE_RAM_TOP);
    wire inSs   = (ea >= SECURE_SEGMENT_RAM_BASE) && (ea <= SECURE_SEGMENT_RAM_TOP);
    wire bsDeny = secCfg_q[`DASC_SEC_BS_EN] && inBs && !fromBootFlash;
    wire ssDeny = secCfg_q[`DASC_SEC_SS_EN] && inSs && !fromSecFlash;
    wire deny   = doAcc && (bsDeny || ssDeny);

    wire addrFault  = misalign || unimpl;
    wire stackFault = overLimit || underflow;
    // write is blocked on an address fault or a denial, not a stack fault; read still completes
    wire blockWr    = addrFault || deny;

    // byte lane handling for writes and reads
    wire [15:0] wrWord  = stackAcc ? pushWord
                        : (byteSize ? {acc.wdata[7:0], acc.wdata[7:0]} : acc.wdata);
    wire [15:0] rdWord  = (unimpl || deny) ? 16'h0000 : memRdata;
    wire [15:0] rdSel   = byteSize ? {8'h00, (ea[0] ? rdWord[15:8] : rdWord[7:0])}
                        : rdWord;

    // wishbone decode
    wire wbReq   = wb_cyc_i && wb_stb_i && !ack_q;
    wire wbWr    = wbReq && wb_we_i;
    wire isWreg  = (wb_adr_i[15:4] == 12'h000);
    wire isSp    = (wb_adr_i == `DASC_OFF_SP);
    wire isLim   = (wb_adr_i == `DASC_OFF_STACK_LIMIT_REG);
    wire isSec   = (wb_adr_i == `DASC_OFF_SECCFG);
    wire isStat  = (wb_adr_i == `DASC_OFF_STATUS);
    wire [2:0] wbIdx = wb_adr_i[3:1];
    wire lo      = wb_sel_i[0];
    wire hi      = wb_sel_i[1];
    wire [15:0] wbWord = wb_dat_i[15:0];
    wire [15:0] wbRd = isWreg ? workReg_q[wbIdx]
                     : isSp   ? stackPointer_q
                     : isLim  ? {stackLimit_q[15:1], 1'b0}
                     : isSec  ? {14'h0000, secCfg_q}
                     : isStat ? {13'h0000, sticky_q} : 16'h0000;

    // stack pointer next value
    wire [15:0] spAfter = isPop ? popEa
                        : isPush ? (stackPointer_q + 16'h0002) : stackPointer_q;

    // working register op result
    wire [15:0] xCur = workReg_q[xopReg];
    wire [15:0] xRes = (xop == DASC_X_SEXT) ? {{8{xCur[7]}}, xCur[7:0]}
                     : (xop == DASC_X_ZEXT) ? {8'h00, xCur[7:0]}
                     : (xop == DASC_X_BLD)  ? {xCur[15:8], rdSel[7:0]}
                     : xCur;

    // working registers: bus writes, extend ops and byte loads
    always_ff @(posedge clk) begin
        for (int i = 0; i < 8; i++) begin
            if (!nrst) begin
                workReg_q[i] <= `DASC_RST_DEFAULT_WORK_REG;
            end else if (xop != DASC_X_NONE && xopReg == 3'(i)) begin
                workReg_q[i] <= xRes;
            end else if (wbWr && isWreg && wbIdx == 3'(i)) begin
                if (lo) workReg_q[i][7:0]  <= wbWord[7:0];
                if (hi) workReg_q[i][15:8] <= wbWord[15:8];
            end
        end
    end

    // stack pointer: stack ops win over bus writes
    always_ff @(posedge clk) begin
        if (!nrst) begin
            stackPointer_q <= `DASC_RST_SP;
        end else if (stackAcc) begin
            stackPointer_q <= spAfter;
        end else if (wbWr && isSp) begin
            stackPointer_q <= {wbWord[15:1], 1'b0};
        end
    end

    // stack limit is not touched by reset
    always_ff @(posedge clk) begin
        if (wbWr && isLim) begin
            stackLimit_q <= {wbWord[15:1], 1'b0};
        end
    end

    // security enables and sticky fault status, set wins over clear
    always_ff @(posedge clk) begin
        if (!nrst) begin
            secCfg_q <= 2'b00;
            sticky_q <= 3'b000;
        end else begin
            if (wbWr && isSec && lo) secCfg_q <= wbWord[1:0];
            sticky_q <= (sticky_q & ~((wbWr && isStat && lo) ? wbWord[2:0] : 3'b000))
                      | {deny, stackFault, addrFault};
        end
    end

    // memory request, read data and single-cycle trap pulses
    always_ff @(posedge clk) begin
        if (!nrst) begin
            memReq_q   <= '0;
            readData_q <= 16'h0000;
            addrErr_q  <= 1'b0;
            stackErr_q <= 1'b0;
            denied_q   <= 1'b0;
        end else begin
            memReq_q.valid  <= doAcc && !(doWrite && blockWr);
            memReq_q.write  <= doWrite;
            memReq_q.isByte <= byteSize;
            memReq_q.addr   <= ea;
            memReq_q.wdata  <= wrWord;
            readData_q      <= rdSel;
            addrErr_q       <= addrFault;
            stackErr_q      <= stackFault;
            denied_q        <= deny;
        end
    end

    // wishbone ack and read data
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= wbReq;
            rdat_q <= {16'h0000, wbRd};
        end
    end

    assign wb_ack_o     = ack_q;
    assign wb_dat_o     = rdat_q;
    assign memReq       = memReq_q;
    assign readData     = readData_q;
    assign addrErrTrap  = addrErr_q;
    assign stackErrTrap = stackErr_q;
    assign accessDenied = denied_q;

    // usage notes for the core and exception logic

    // every check looks at one access per cycle

    // a stack op in the same cycle as acc wins

    // acc is ignored while stackOp is not none, except that a push writes acc.wdata

    // direct forms replace acc.addr as the address

    // near form keeps only the low 13 address bits

    // move form passes the full 16-bit address

    // word size is forced when accWordOnly is high

    // stack accesses are always word sized

    // a byte access may use an odd address

    // a word access at an odd address is a fault

    // a faulting read of an implemented, permitted address still returns its data

    // a write with an address fault never reaches memory

    // denied writes are dropped in the same way

    // denied and unimplemented reads return zero

    // memRdata must settle within the same cycle

    // the memory sees the request one cycle later

    // readData stands for one cycle only

    // trap outputs are one-cycle pulses

    // a fault on every cycle gives a pulse each cycle

    // the exception logic latches what it needs

    // sticky status keeps a record for software

    // a status bit set and cleared together stays set

    // status bits clear by writing ones

    // the stack pointer moves by two per access

    // pops subtract before the address is formed

    // pushes use the pointer and then add two

    // limit compare uses the push address itself

    // a push at the limit address is still allowed

    // the first push above the limit traps

    // the limit compare is not done on pops

    // underflow is checked on every stack access

    // a pop with the pointer at the bottom word traps underflow

    // the pointer still moves on a trapped access

    // software restores the pointer in the handler

    // the limit register has no reset value

    // software must write the limit before pushes

    // an unwritten limit makes push checks unknown

    // the limit low bit is dropped on write

    // the limit low bit always reads back as zero

    // the pointer low bit is dropped on write too

    // a stack op beats a bus write of the pointer

    // a register op beats a bus write of that reg

    // the bus write is lost in that case

    // software should not race the core on them

    // a call push clears the counter upper byte

    // an exception push carries the status byte

    // only the low counter byte is pushed here

    // exception pushes share every stack check

    // byte writes place the byte on both halves

    // memory picks the half by address bit zero

    // byte reads pick the half by address bit zero

    // the picked byte lands in the low read bits

    // a byte load keeps the register upper byte

    // sign-extend copies bit seven upward

    // zero-extend clears the upper byte

    // secure windows are fixed by parameters

    // each window has its own enable bit

    // the origin flags come from the fetch side

    // a denied access also raises accessDenied

    // the bus answers every request in one cycle

    // ack drops the cycle after it was given

    // unmapped bus reads return zero

    // unmapped bus writes are ignored

    // only the low two byte selects are used

    // upper read data bits are always zero

    // all outputs come from flip-flops

    // all registers run on the rising clock edge

    // reset is synchronous and active low

    // the pointer resets to the bottom of ram
endmodule : dasc_data_access_stack_check

//--- verif/dasc_checker.sv
`timescale 1ns/100ps
module dasc_checker import dasc_pkg::*; #(
    parameter logic [15:0] IMPL_TOP = 16'h27ff
) (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire dasc_acc_s   acc,
    input wire logic        accDirect,
    input wire logic        accMove,
    input wire logic [15:0] accDirAddr,
    input wire logic        accWordOnly,
    input wire dasc_op_e    stackOp,
    input wire logic [15:0] pcValue,
    input wire logic [7:0]  statusLowByte,
    input wire dasc_acc_s   memReq,
    input wire logic        addrErrTrap
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // plain data access, no stack op and no direct form
    wire       plainAcc = acc.valid && !accDirect && stackOp == DASC_OP_NONE;
    wire       dirAcc   = acc.valid && accDirect && stackOp == DASC_OP_NONE;
    wire [7:0] pcLow    = pcValue[7:0];
    chk_odd_word: assert property (
        plainAcc && (!acc.isByte || accWordOnly) && acc.addr[0] |=> addrErrTrap)
        else $error("odd word access without address trap");
    chk_odd_write: assert property (
        plainAcc && acc.write && !acc.isByte && acc.addr[0] |=> !memReq.valid)
        else $error("odd word write reached memory");
    chk_unimpl_trap: assert property (plainAcc && acc.addr > IMPL_TOP |=> addrErrTrap)
        else $error("unimplemented access without trap");
    chk_byte_lanes: assert property (
        memReq.valid && memReq.write && memReq.isByte |-> memReq.wdata[15:8] == memReq.wdata[7:0])
        else $error("byte write not on both lanes");
    chk_call_clear: assert property (
        stackOp == DASC_OP_CALL |=> !memReq.valid || memReq.wdata == {8'h00, $past(pcLow)})
        else $error("call push upper byte not clear");
    chk_excp_status: assert property (
        stackOp == DASC_OP_EXCP |=> !memReq.valid
            || memReq.wdata == {$past(statusLowByte), $past(pcLow)})
        else $error("exception push word wrong");
    chk_near_range: assert property (dirAcc && !accMove |=> !memReq.valid || memReq.addr < 16'h2000)
        else $error("near direct address out of range");
    chk_move_addr: assert property (
        dirAcc && accMove |=> !memReq.valid || memReq.addr == $past(accDirAddr))
        else $error("move direct address changed");
    chk_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus cycle not acknowledged");
endmodule : dasc_checker
bind dasc_data_access_stack_check dasc_checker #(.IMPL_TOP(IMPL_TOP)) u_chk (.clk, .nrst,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .acc, .accDirect, .accMove, .accDirAddr, .accWordOnly,
    .stackOp, .pcValue, .statusLowByte, .memReq, .addrErrTrap);

//--- verif/dasc_mem_model.sv
`timescale 1ns/100ps
// data memory behind the block: each word reads back a pattern of its own address
module dasc_mem_model (
    input  wire dasc_pkg::dasc_acc_s acc,
    input  wire logic                accDirect,
    input  wire logic [15:0]         accDirAddr,
    output logic [15:0]              memRdata
);
    import dasc_pkg::*;
    wire [15:0] byteEa = accDirect ? accDirAddr : acc.addr;
    wire [15:0] ea     = {byteEa[15:1], 1'b0}; // word holding the byte
    assign memRdata = {ea[7:0] ^ 8'ha5, ea[15:8] ^ 8'hc3};
endmodule : dasc_mem_model

//--- verif/data_access_stack_check_tb.sv
`timescale 1ns/100ps
`include "dasc_defines.svh"
module data_access_stack_check_tb;
    import dasc_pkg::*;
    logic clk = 0, nrst = 0, wbCyc = 0, wbWe = 0, accDirect = 0, accMove = 0;
    logic accWordOnly = 0, fromBootFlash = 0, fromSecFlash = 0, wbAck, addrErrTrap;
    logic stackErrTrap, accessDenied;
    logic [15:0] wbAdr = '0, accDirAddr = '0, pcValue = '0, memRdata, readData, e;
    logic [31:0] wbDat = '0, wbDatO, r, seed = 49195;
    logic [7:0]  statusLowByte = '0, b;
    logic [2:0]  xopReg = '0;
    dasc_acc_s   acc = '0, memReq;
    dasc_op_e    stackOp = DASC_OP_NONE;
    dasc_xop_e   xop = DASC_X_NONE;
    int          mismatches = 0, nChecks = 0;
    always #2 clk = ~clk;
    dasc_data_access_stack_check u_dut (.clk, .nrst, .wb_cyc_i(wbCyc), .wb_stb_i(wbCyc),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'h3), .wb_dat_i(wbDat), .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck), .acc, .accDirect, .accMove, .accDirAddr, .accWordOnly, .fromBootFlash,
        .fromSecFlash, .stackOp, .pcValue, .statusLowByte, .xop, .xopReg, .memReq, .memRdata,
        .readData, .addrErrTrap, .stackErrTrap, .accessDenied);
    dasc_mem_model u_mem (.acc, .accDirect, .accDirAddr, .memRdata);
    function automatic logic [15:0] pat(input logic [15:0] a);
        return {a[7:0] ^ 8'ha5, a[15:8] ^ 8'hc3};
    endfunction : pat
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction : xs
    function automatic dasc_acc_s mk(input logic w, y, input logic [15:0] a, d);
        return '{1'b1, w, y, a, d};
    endfunction : mk
    task automatic check(input string nm, input logic [32:0] ex, got);
        nChecks++;
        if (got !== ex) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask : check
    task automatic final_report;
        if (mismatches == 0 && nChecks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    // classic single cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int i;
        wbCyc <= 1;
        wbWe <= w;
        wbAdr <= a;
        wbDat <= d;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (wbAck !== 1'b1 && i < 20);
        r = wbDatO;
        if (i >= 20) check("wb ack", 1, 0);
        wbCyc <= 0;
        @(posedge clk);
    endtask : wb
    // one core request, outputs looked at after the answering edge
    task automatic core(input dasc_acc_s a, input dasc_op_e op);
        acc <= a;
        stackOp <= op;
        @(posedge clk);
        acc <= '0;
        stackOp <= DASC_OP_NONE;
        xop <= DASC_X_NONE;
        accDirect <= 0;
        #1;
    endtask : core
    initial begin
        #100000;
        mismatches++;
        final_report();
    end
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1;
        @(posedge clk);
        wb(0, `DASC_OFF_SP, 0);
        check("sp reset", 16'h0800, r);
        wb(0, `DASC_OFF_WREG5, 0);
        check("w5 reset", 0, r);
        wb(0, 16'h0100, 0);
        check("unmapped", 0, r);
        wb(1, `DASC_OFF_WREG1, 32'h1234);
        xop <= DASC_X_BLD;
        xopReg <= 3'd1;
        core(mk(0, 1, 16'h1001, 0), DASC_OP_NONE);
        b = pat(16'h1000) >> 8;
        check("byte read", b, readData[7:0]);
        wb(0, `DASC_OFF_WREG1, 0);
        check("byte load", {8'h12, b}, r);
        xop <= DASC_X_SEXT;
        core('0, DASC_OP_NONE);
        wb(0, `DASC_OFF_WREG1, 0);
        check("sign ext", {{8{b[7]}}, b}, r);
        xop <= DASC_X_ZEXT;
        core('0, DASC_OP_NONE);
        wb(0, `DASC_OFF_WREG1, 0);
        check("zero ext", {8'h00, b}, r);
        core(mk(0, 0, 16'h1003, 0), DASC_OP_NONE);
        check("odd read trap", 1, addrErrTrap);
        core(mk(1, 0, 16'h1005, 16'h7777), DASC_OP_NONE);
        check("odd write", 2'b10, {addrErrTrap, memReq.valid});
        accWordOnly <= 1;
        core(mk(0, 1, 16'h1007, 0), DASC_OP_NONE);
        check("word only trap", 1, addrErrTrap);
        accWordOnly <= 0;
        core(mk(0, 0, 16'h3000, 0), DASC_OP_NONE);
        check("unimpl", 17'h10000, {addrErrTrap, readData});
        for (int k = 0; k < 2; k++) begin
            accDirect <= 1;
            accMove <= k[0];
            accDirAddr <= 16'hf010;
            core(mk(0, 0, 0, 0), DASC_OP_NONE);
            check("direct addr", k ? 16'hf010 : 16'h1010, memReq.addr);
        end
        wb(1, `DASC_OFF_STACK_LIMIT_REG, 32'h0803);
        wb(0, `DASC_OFF_STACK_LIMIT_REG, 0);
        check("limit bit0", 16'h0802, r);
        for (int k = 0; k < 3; k++) begin
            core(mk(1, 0, 0, 16'h4321), DASC_OP_PUSH);
            check("push trap", k == 2, stackErrTrap);
            if (k < 2) check("push addr", 16'h0800 + 2 * k, memReq.addr);
        end
        wb(1, `DASC_OFF_STACK_LIMIT_REG, 32'h1ffe);
        wb(1, `DASC_OFF_SP, 32'h1000);
        pcValue <= 16'habcd;
        statusLowByte <= 8'h5e;
        core('0, DASC_OP_CALL);
        check("call push", 32'h100000cd, {memReq.addr, memReq.wdata});
        core('0, DASC_OP_EXCP);
        check("excp push", 32'h10025ecd, {memReq.addr, memReq.wdata});
        core('0, DASC_OP_POP);
        check("pop addr", 16'h1002, memReq.addr);
        wb(0, `DASC_OFF_SP, 0);
        check("sp after pop", 16'h1002, r);
        wb(1, `DASC_OFF_SP, 32'h0800);
        core('0, DASC_OP_POP);
        check("underflow", 1, stackErrTrap);
        wb(1, `DASC_OFF_SECCFG, 32'h3);
        for (int k = 0; k < 4; k++) begin
            fromBootFlash <= k[0] & !k[1];
            fromSecFlash <= k[0] & k[1];
            core(mk(0, 0, k[1] ? 16'h0910 : 16'h0810, 0), DASC_OP_NONE);
            check("secure ram", !k[0], accessDenied);
        end
        fromBootFlash <= 0;
        fromSecFlash <= 0;
        for (int k = 0; k < 40; k++) begin
            seed = xs(seed);
            e = {4'b0001, seed[11:1], 1'b0};
            core(mk(seed[20], 0, e, seed[31:16]), DASC_OP_NONE);
            if (seed[20]) check("wr req", {1'b1, e, seed[31:16]},
                {memReq.valid, memReq.addr, memReq.wdata});
            else check("rd data", pat(e), readData);
        end
        final_report();
    end
endmodule : data_access_stack_check_tb
